// >>> common/servo_pkg.sv
// servo supervisor package: codes, timing, register map
// assumes a 200 MHz aclk and an AXI4-Lite register bus
package servo_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned NS_PER_MS        = 1_000_000;
  localparam int unsigned NS_PER_US        = 1_000;
  localparam int unsigned CYC_PER_MS       = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned SEEK_TIMEOUT_MS  = 65;
  localparam int unsigned SEEK_TIMEOUT_CYC = SEEK_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned LOAD_TIMEOUT_MS  = 1000;
  localparam int unsigned LOAD_TIMEOUT_CYC = LOAD_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned TRAVEL_MS        = 200;
  localparam int unsigned TRAVEL_CYC       = TRAVEL_MS * CYC_PER_MS;
  localparam int unsigned DEMOD_WAIT_MS    = 10;
  localparam int unsigned DEMOD_WAIT_CYC   = DEMOD_WAIT_MS * CYC_PER_MS;
  localparam int unsigned PULSE_GAP_MS     = 5;
  localparam int unsigned PULSE_GAP_CYC    = PULSE_GAP_MS * CYC_PER_MS;
  localparam int unsigned GB_WINDOW_MS     = 20;
  localparam int unsigned GB_WINDOW_CYC    = GB_WINDOW_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_MAX_MS    = 10;
  localparam int unsigned SETTLE_MAX_CYC   = SETTLE_MAX_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_HOLD_US   = 5;
  localparam int unsigned SETTLE_HOLD_CYC  = SETTLE_HOLD_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned TMR_W            = 28;
  localparam int unsigned CNT_W            = 3;
  localparam logic [CNT_W-1:0] GB_PULSES   = 3'h4;
  // ----------------------------------------
  // status codes
  // ----------------------------------------
  localparam logic [7:0] CODE_NONE     = 8'h00;
  localparam logic [7:0] CODE_CYL_ZERO = 8'h00;
  localparam logic [7:0] CODE_NO_DEMOD = 8'h24;
  localparam logic [7:0] CODE_NO_PULSE = 8'h25;
  localparam logic [7:0] CODE_LOAD_TMO = 8'h26;
  localparam logic [7:0] CODE_CALIB    = 8'h2C;
  localparam logic [7:0] CODE_RTZ_DMOD = 8'h31;
  localparam logic [7:0] CODE_TRAVEL   = 8'h33;
  localparam logic [7:0] CODE_GB_PULSE = 8'h37;
  localparam logic [7:0] CODE_INNER_GB = 8'h40;
  localparam logic [7:0] CODE_OUTER_GB = 8'h43;
  localparam logic [7:0] CODE_SEEK_TMO = 8'h46;
  localparam logic [7:0] CODE_SETTLE   = 8'h4A;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] REG_CMD    = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam int unsigned CYL_W      = 10;
  localparam int unsigned CMD_RTZ    = 12;
  localparam int unsigned ST_SEEKERR = 8;
  localparam int unsigned ST_SEEKEND = 9;
  localparam int unsigned ST_FAULT   = 10;
  localparam int unsigned ST_ONCYL   = 11;
  localparam int unsigned ST_SERVO   = 12;
  localparam int unsigned ST_FIRST   = 13;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {
    PH_IDLE, PH_DEMOD, PH_MOVE, PH_GB, PH_CALIB, PH_SEEK, PH_SETTLE, PH_FAULT
  } phase_t;
endpackage

// >>> design/phase_timer.sv
// saturating cycle counter, restarted by clear
// assumes clear is synchronous to aclk
`timescale 1ns/100ps
module phase_timer
  import servo_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control and count
  input  wire logic             clear,
  output logic      [TMR_W-1:0] count_ff
);
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_ff <= '0;
    end else if (count_ff != '1) begin
      count_ff <= count_ff + 1'b1;
    end
  end
endmodule

// >>> design/pulse_counter.sv
// counts cylinder pulses up to a small ceiling
// assumes one-cycle pulses synchronous to aclk
`timescale 1ns/100ps
module pulse_counter
  import servo_pkg::*;
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pulses and count
  input  wire logic             clear,
  input  wire logic             pulse,
  output logic      [CNT_W-1:0] count_ff
);
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_ff <= '0;
    end else if (pulse && count_ff != '1) begin
      count_ff <= count_ff + 1'b1;
    end
  end
endmodule

// >>> design/servo_fault_status_supervisor.sv
// servo supervisor: load, return to zero and seek checks with status codes
// assumes synchronous servo inputs and an AXI4-Lite master on aclk
//
// Overview of operation
// - load: no demodulator ok within its wait posts code 24
// - first-seek failures other than 2C, 40, 43, 46 light the initial seek indicator
// - first-seek failures other than 2C, 40, 43, 46 light fault indicator and fault line
// - every servo failure code raises seek error and seek end
// - after 24, 25, 26 the fault reset switch clears and reloads
// - load: no cylinder pulses while moving outward posts code 25
// - load overall timeout posts code 26
// - calibrate seek error posts 2C; switch starts another load
// - 2C, 40, 43, 46 disable servo, spindle keeps running
// - return to zero losing demodulator ok posts 31, spindle runs
// - after 31 a return-to-zero command clears error and retries
// - load or return to zero: slow travel to guard band posts 33
// - four cylinder pulses missing in guard band posts 37
// - 33/37 cleared by switch on first seek, else by return to zero
// - inner guard band seen during normal seek posts 40
// - outer guard band seen during normal seek posts 43
// - normal seek over 65 ms to on cylinder posts 46
// - after 40, 43, 46 return to zero clears error, seeks cylinder 0
// - on-cylinder sense slow to settle posts 4A with error lines
// - status is a two-digit hex code updated while running
// - success shows upper eight cylinder bits until the next success or error
// - an error code holds until its own recovery action
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
module servo_fault_status_supervisor
  import servo_pkg::*;
#(
  parameter int unsigned SEEK_TMO  = SEEK_TIMEOUT_CYC,
  parameter int unsigned LOAD_TMO  = LOAD_TIMEOUT_CYC,
  parameter int unsigned TRAVEL    = TRAVEL_CYC,
  parameter int unsigned DEMOD_MAX = DEMOD_WAIT_CYC,
  parameter int unsigned GAP_MAX   = PULSE_GAP_CYC,
  parameter int unsigned GB_MAX    = GB_WINDOW_CYC,
  parameter int unsigned SETTLE    = SETTLE_MAX_CYC
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready_ff,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready_ff,
  output logic [1:0]       bresp_ff,
  output logic             bvalid_ff,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready_ff,
  output logic [31:0]      rdata_ff,
  output logic [1:0]       rresp_ff,
  output logic             rvalid_ff,
  input  wire logic        rready,
  // servo sense inputs
  input  wire logic        demod_ok,
  input  wire logic        cyl_pulse,
  input  wire logic        outer_gb,
  input  wire logic        inner_gb_pulse,
  input  wire logic        outer_gb_pulse,
  input  wire logic        on_cyl_sense,
  input  wire logic        calib_done,
  input  wire logic        calib_err,
  input  wire logic        fault_reset_sw,
  // status and control outputs
  output logic [7:0]       status_code_ff,
  output logic             seek_error_ff,
  output logic             seek_end_ff,
  output logic             fault_line_ff,
  output logic             fault_indicator_ff,
  output logic             initial_seek_indicator_ff,
  output logic             servo_enable_ff,
  output logic             spindle_run_ff,
  output logic             on_cylinder_ff
);
  // ----------------------------------------
  // code groups
  // ----------------------------------------
  function automatic logic first_group(input logic [7:0] c);
    first_group = (c == CODE_NO_DEMOD) || (c == CODE_NO_PULSE) || (c == CODE_LOAD_TMO) ||
                  (c == CODE_RTZ_DMOD) || (c == CODE_TRAVEL) || (c == CODE_GB_PULSE) ||
                  (c == CODE_SETTLE);
  endfunction

  function automatic logic disable_group(input logic [7:0] c);
    disable_group = (c == CODE_CALIB) || (c == CODE_INNER_GB) ||
                    (c == CODE_OUTER_GB) || (c == CODE_SEEK_TMO);
  endfunction

  function automatic logic switch_clears(input logic [7:0] c, input logic first);
    switch_clears = (c == CODE_NO_DEMOD) || (c == CODE_NO_PULSE) || (c == CODE_LOAD_TMO) ||
                    (c == CODE_CALIB) ||
                    (first && ((c == CODE_TRAVEL) || (c == CODE_GB_PULSE) || (c == CODE_SETTLE)));
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  phase_t                state_ff;
  phase_t                nxt_state;
  logic                  rtz_op_ff;
  logic                  first_seek_ff;
  logic                  sw_q_ff;
  logic [CYL_W-1:0]      target_ff;
  logic [31:0]           aw_addr_ff;
  logic [31:0]           w_data_ff;
  logic [3:0]            w_strb_ff;
  logic [TMR_W-1:0]      phase_cnt;
  logic [TMR_W-1:0]      gap_cnt;
  logic [TMR_W-1:0]      load_cnt;
  logic [TMR_W-1:0]      hold_cnt;
  logic [CNT_W-1:0]      gb_cnt;
  logic [7:0]            err_code;
  logic [7:0]            ok_code;
  logic                  post_err;
  logic                  post_ok;
  logic                  clear_go;
  logic                  start_rtz;
  logic                  start_seek;
  logic                  in_load;
  logic                  sw_press;
  logic                  wr_go;
  logic                  cmd_go;
  logic                  cmd_rtz;

  assign sw_press = fault_reset_sw && !sw_q_ff;
  assign wr_go    = !awready_ff && !wready_ff && !bvalid_ff;
  assign cmd_go   = wr_go && (aw_addr_ff == REG_CMD) && (w_strb_ff[1:0] == 2'b11);
  assign cmd_rtz  = w_data_ff[CMD_RTZ];
  assign in_load  = !rtz_op_ff && (state_ff inside {PH_DEMOD, PH_MOVE, PH_GB, PH_CALIB});

  // ----------------------------------------
  // timers
  // ----------------------------------------
  phase_timer u_phase (.aclk(aclk), .aresetn(aresetn), .clear(nxt_state != state_ff),
                       .count_ff(phase_cnt));
  phase_timer u_gap (.aclk(aclk), .aresetn(aresetn), .clear(cyl_pulse || nxt_state != state_ff),
                     .count_ff(gap_cnt));
  phase_timer u_load (.aclk(aclk), .aresetn(aresetn), .clear(!in_load), .count_ff(load_cnt));
  phase_timer u_hold (.aclk(aclk), .aresetn(aresetn), .clear(!on_cyl_sense || state_ff != PH_SETTLE),
                      .count_ff(hold_cnt));
  pulse_counter u_gbp (.aclk(aclk), .aresetn(aresetn), .clear(state_ff != PH_GB), .pulse(cyl_pulse),
                       .count_ff(gb_cnt));

  // ----------------------------------------
  // sequence checks
  // ----------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    err_code   = CODE_NONE;
    post_ok    = 1'b0;
    clear_go   = 1'b0;
    start_rtz  = 1'b0;
    start_seek = 1'b0;
    ok_code    = (state_ff == PH_SETTLE) ? target_ff[CYL_W-1:2] : CODE_CYL_ZERO;
    if (in_load && load_cnt >= TMR_W'(LOAD_TMO)) begin
      err_code = CODE_LOAD_TMO;
    end else begin
      case (state_ff)
        PH_IDLE: begin
          if (cmd_go && cmd_rtz) begin
            start_rtz = 1'b1;
            nxt_state = PH_MOVE;
          end else if (cmd_go) begin
            start_seek = 1'b1;
            nxt_state  = PH_SEEK;
          end
        end
        PH_DEMOD: begin
          if (demod_ok) begin
            nxt_state = PH_MOVE;
          end else if (phase_cnt >= TMR_W'(DEMOD_MAX)) begin
            err_code = CODE_NO_DEMOD;
          end
        end
        PH_MOVE: begin
          if (rtz_op_ff && !demod_ok) begin
            err_code = CODE_RTZ_DMOD;
          end else if (phase_cnt >= TMR_W'(TRAVEL)) begin
            err_code = CODE_TRAVEL;
          end else if (!rtz_op_ff && gap_cnt >= TMR_W'(GAP_MAX)) begin
            err_code = CODE_NO_PULSE;
          end else if (outer_gb) begin
            nxt_state = PH_GB;
          end
        end
        PH_GB: begin
          if (rtz_op_ff && !demod_ok) begin
            err_code = CODE_RTZ_DMOD;
          end else if (gb_cnt >= GB_PULSES) begin
            post_ok   = rtz_op_ff;
            nxt_state = rtz_op_ff ? PH_IDLE : PH_CALIB;
          end else if (phase_cnt >= TMR_W'(GB_MAX)) begin
            err_code = CODE_GB_PULSE;
          end
        end
        PH_CALIB: begin
          if (calib_err) begin
            err_code = CODE_CALIB;
          end else if (calib_done) begin
            post_ok   = 1'b1;
            nxt_state = PH_IDLE;
          end
        end
        PH_SEEK: begin
          if (inner_gb_pulse) begin
            err_code = CODE_INNER_GB;
          end else if (outer_gb_pulse) begin
            err_code = CODE_OUTER_GB;
          end else if (phase_cnt >= TMR_W'(SEEK_TMO)) begin
            err_code = CODE_SEEK_TMO;
          end else if (on_cyl_sense) begin
            nxt_state = PH_SETTLE;
          end
        end
        PH_SETTLE: begin
          if (hold_cnt >= TMR_W'(SETTLE_HOLD_CYC)) begin
            post_ok   = 1'b1;
            nxt_state = PH_IDLE;
          end else if (phase_cnt >= TMR_W'(SETTLE)) begin
            err_code = CODE_SETTLE;
          end
        end
        default: begin
          if (sw_press && switch_clears(status_code_ff, first_seek_ff)) begin
            clear_go  = 1'b1;
            nxt_state = PH_DEMOD;
          end else if (cmd_go && cmd_rtz && !switch_clears(status_code_ff, first_seek_ff)) begin
            clear_go  = 1'b1;
            start_rtz = 1'b1;
            nxt_state = PH_MOVE;
          end
        end
      endcase
    end
    post_err = (err_code != CODE_NONE);
    if (post_err) begin
      nxt_state = PH_FAULT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= PH_DEMOD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtz_op_ff <= 1'b0;
      target_ff <= '0;
      sw_q_ff   <= 1'b0;
    end else begin
      sw_q_ff <= fault_reset_sw;
      if (start_rtz) begin
        rtz_op_ff <= 1'b1;
        target_ff <= '0;
      end else if (start_seek) begin
        rtz_op_ff <= 1'b0;
        target_ff <= w_data_ff[CYL_W-1:0];
      end else if (clear_go) begin
        rtz_op_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_seek_ff <= 1'b1;
    end else if (post_ok && state_ff == PH_CALIB) begin
      first_seek_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // status code and lines
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_code_ff <= CODE_NONE;
    end else if (post_err) begin
      status_code_ff <= err_code;
    end else if (post_ok) begin
      status_code_ff <= ok_code;
    end else if (clear_go) begin
      status_code_ff <= CODE_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seek_error_ff             <= 1'b0;
      seek_end_ff               <= 1'b0;
      fault_line_ff             <= 1'b0;
      fault_indicator_ff        <= 1'b0;
      initial_seek_indicator_ff <= 1'b0;
      servo_enable_ff           <= 1'b0;
      spindle_run_ff            <= 1'b0;
      on_cylinder_ff            <= 1'b0;
    end else begin
      spindle_run_ff <= 1'b1;
      if (post_err) begin
        seek_error_ff  <= 1'b1;
        seek_end_ff    <= 1'b1;
        on_cylinder_ff <= 1'b0;
        if (first_seek_ff && first_group(err_code)) begin
          initial_seek_indicator_ff <= 1'b1;
          fault_line_ff             <= 1'b1;
          fault_indicator_ff        <= 1'b1;
        end
        if (disable_group(err_code)) begin
          servo_enable_ff <= 1'b0;
        end
      end else if (clear_go) begin
        seek_error_ff             <= 1'b0;
        seek_end_ff               <= 1'b0;
        fault_line_ff             <= 1'b0;
        fault_indicator_ff        <= 1'b0;
        initial_seek_indicator_ff <= 1'b0;
        servo_enable_ff           <= 1'b1;
      end else if (start_seek || start_rtz) begin
        seek_end_ff    <= 1'b0;
        on_cylinder_ff <= 1'b0;
      end else if (post_ok) begin
        seek_end_ff    <= 1'b1;
        on_cylinder_ff <= 1'b1;
      end else if (state_ff == PH_DEMOD) begin
        servo_enable_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (aw_addr_ff == REG_CMD || aw_addr_ff == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
      if (araddr == REG_CMD) begin
        rdata_ff[CYL_W-1:0] <= target_ff;
        rdata_ff[CMD_RTZ]   <= rtz_op_ff;
      end else if (araddr == REG_STATUS) begin
        rdata_ff[7:0]        <= status_code_ff;
        rdata_ff[ST_SEEKERR] <= seek_error_ff;
        rdata_ff[ST_SEEKEND] <= seek_end_ff;
        rdata_ff[ST_FAULT]   <= fault_line_ff;
        rdata_ff[ST_ONCYL]   <= on_cylinder_ff;
        rdata_ff[ST_SERVO]   <= servo_enable_ff;
        rdata_ff[ST_FIRST]   <= first_seek_ff;
      end else begin
        rresp_ff <= RESP_SLVERR;
      end
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_no_demod_code: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_DEMOD && !demod_ok && phase_cnt >= TMR_W'(DEMOD_MAX) && !in_load_tmo()
    |=> status_code_ff == CODE_NO_DEMOD && state_ff == PH_FAULT)
    else $error("code 24 not posted");

  a_first_lights: assert property (
    @(posedge aclk) disable iff (!aresetn)
    post_err && first_seek_ff && first_group(err_code)
    |=> initial_seek_indicator_ff && fault_line_ff && fault_indicator_ff)
    else $error("first seek indicators missing");

  a_err_lines: assert property (
    @(posedge aclk) disable iff (!aresetn)
    post_err |=> seek_error_ff && seek_end_ff && !on_cylinder_ff)
    else $error("error lines not raised");

  a_switch_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_FAULT && sw_press && switch_clears(status_code_ff, first_seek_ff)
    |=> state_ff == PH_DEMOD && !seek_error_ff && status_code_ff == CODE_NONE)
    else $error("switch did not reload");

  a_seek_timeout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_SEEK && phase_cnt >= TMR_W'(SEEK_TMO) && !inner_gb_pulse && !outer_gb_pulse
    |=> status_code_ff == CODE_SEEK_TMO && !servo_enable_ff && spindle_run_ff)
    else $error("seek timeout not posted");

  a_code_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_FAULT && !clear_go |=> $stable(status_code_ff) && state_ff == PH_FAULT)
    else $error("error code changed early");

  a_rtz_recover: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_FAULT && cmd_go && cmd_rtz && disable_group(status_code_ff)
    && status_code_ff != CODE_CALIB
    |=> !seek_error_ff && state_ff == PH_MOVE && target_ff == '0 ##1 rtz_op_ff)
    else $error("return to zero did not recover");

  a_ok_cylinder: assert property (
    @(posedge aclk) disable iff (!aresetn)
    post_ok && state_ff == PH_SETTLE
    |=> status_code_ff == $past(target_ff[CYL_W-1:2]) && on_cylinder_ff)
    else $error("destination code wrong");

  a_settle_code: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_ff == PH_SETTLE && phase_cnt >= TMR_W'(SETTLE) && hold_cnt < TMR_W'(SETTLE_HOLD_CYC)
    |=> status_code_ff == CODE_SETTLE && seek_error_ff && seek_end_ff)
    else $error("settle code missing");

  function automatic logic in_load_tmo();
    in_load_tmo = in_load && load_cnt >= TMR_W'(LOAD_TMO);
  endfunction
endmodule

// >>> verification/disk_ctrl_model.sv
// disk controller model: axi4-lite master tasks
// assumes the supervisor is the slave on aclk
`timescale 1ns/100ps
module disk_ctrl_model (
  // clock
  input  wire logic        aclk,
  // write channels and read response
  output logic      [31:0] awaddr, wdata,
  output logic      [3:0]  wstrb,
  output logic             awvalid, wvalid, bready,
  input  wire logic        awready_ff, wready_ff, bvalid_ff,
  input  wire logic [1:0]  bresp_ff, rresp_ff,
  // read channels
  output logic      [31:0] araddr,
  output logic             arvalid, rready,
  input  wire logic        arready_ff, rvalid_ff,
  input  wire logic [31:0] rdata_ff
);
  initial {awaddr, wdata, wstrb, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
    do begin
      @(posedge aclk);
      if (awvalid && awready_ff) awvalid <= 1'b0;
      if (wvalid && wready_ff) wvalid <= 1'b0;
      if (bready && bvalid_ff) begin
        bready <= 1'b0;
        r = bresp_ff;
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arvalid && arready_ff) arvalid <= 1'b0;
      if (rready && rvalid_ff) begin
        rready <= 1'b0;
        {d, r} = {rdata_ff, rresp_ff};
      end
    end while (arvalid || rready);
  endtask
endmodule

// >>> verification/servo_fault_status_supervisor_bench.sv
// supervisor bench: load fault, load, seek, guard band, rtz, timeout
// assumes the disk controller model as bus master
`timescale 1ns/100ps
module servo_fault_status_supervisor_bench
  import servo_pkg::*;
();
  logic aclk = 0, aresetn = 0, pen = 0;
  logic [2:0] pc = 0;
  logic [31:0] awaddr, wdata, araddr, rdata_ff, d;
  logic [3:0] wstrb;
  logic [1:0] bresp_ff, rresp_ff, r;
  logic awvalid, wvalid, bready, arvalid, rready, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic demod_ok = 0, cyl_pulse = 0, outer_gb = 0, inner_gb_pulse = 0, on_cyl_sense = 0, calib_done = 0;
  logic fault_reset_sw = 0, outer_gb_pulse = 0, calib_err = 0;
  logic [7:0] status_code_ff;
  logic seek_error_ff, seek_end_ff, fault_line_ff, fault_indicator_ff, initial_seek_indicator_ff;
  logic servo_enable_ff, spindle_run_ff, on_cylinder_ff;
  wire logic [7:0] lines = {seek_error_ff, seek_end_ff, fault_line_ff, fault_indicator_ff,
    initial_seek_indicator_ff, servo_enable_ff, spindle_run_ff, on_cylinder_ff};
  int failures = 0, checks_done = 0;
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    pc <= pc + 3'h1;
    cyl_pulse <= pen && pc == 3'h0;
  end
  servo_fault_status_supervisor #(.SEEK_TMO(200), .LOAD_TMO(2000), .DEMOD_MAX(50), .GB_MAX(100),
    .SETTLE(1200)) dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready_ff,
    .wdata, .wstrb, .wvalid, .wready_ff, .bresp_ff, .bvalid_ff, .bready, .araddr, .arvalid, .arready_ff,
    .rdata_ff, .rresp_ff, .rvalid_ff, .rready, .demod_ok, .cyl_pulse, .outer_gb, .inner_gb_pulse,
    .outer_gb_pulse, .on_cyl_sense, .calib_done, .calib_err, .fault_reset_sw,
    .status_code_ff, .seek_error_ff, .seek_end_ff, .fault_line_ff, .fault_indicator_ff,
    .initial_seek_indicator_ff, .servo_enable_ff, .spindle_run_ff, .on_cylinder_ff);
  disk_ctrl_model ctrl_u (.aclk, .awaddr, .wdata, .wstrb, .awvalid, .wvalid, .bready, .awready_ff,
    .wready_ff, .bvalid_ff, .bresp_ff, .rresp_ff, .araddr, .arvalid, .rready, .arready_ff, .rvalid_ff,
    .rdata_ff);
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_code(input logic [7:0] c);
    for (int i = 0; i < 3000 && status_code_ff !== c; i++) @(posedge aclk);
    chk("code", c, status_code_ff);
  endtask
  task automatic wr_cmd(input logic [31:0] v);
    ctrl_u.wr(REG_CMD, v, r);
    chk("bresp", 8'h00, {6'h0, r});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_load;
    wait_code(CODE_NO_DEMOD);
    chk("lines", 8'hFE, lines);
    {demod_ok, pen, fault_reset_sw} <= 3'b111;
    cyc(3);
    fault_reset_sw <= 1'b0;
    wait_code(CODE_NONE);
    cyc(20);
    outer_gb <= 1'b1;
    cyc(60);
    calib_err <= 1'b1;
    cyc(1);
    calib_err <= 1'b0;
    wait_code(CODE_CALIB);
    chk("lines", 8'hC2, lines);
    fault_reset_sw <= 1'b1;
    cyc(3);
    fault_reset_sw <= 1'b0;
    cyc(60);
    calib_done <= 1'b1;
    cyc(1);
    calib_done <= 1'b0;
    cyc(3);
    chk("load", 8'h47, lines);
    $display("load test done");
  endtask
  task automatic t_seek;
    {outer_gb, pen, on_cyl_sense} <= 3'b001;
    wr_cmd(32'h0000_0334);
    wait_code(8'hCD);
    chk("oncyl", 8'h01, {7'h0, on_cylinder_ff});
    on_cyl_sense <= 1'b0;
    wr_cmd(32'h0000_0100);
    inner_gb_pulse <= 1'b1;
    cyc(1);
    inner_gb_pulse <= 1'b0;
    wait_code(CODE_INNER_GB);
    chk("lines", 8'hC2, lines);
    {outer_gb, pen} <= 2'b11;
    wr_cmd(32'h0000_1000);
    cyc(100);
    chk("rtz", 8'h47, lines);
    wait_code(CODE_CYL_ZERO);
    $display("seek test done");
  endtask
  task automatic t_tmo;
    {outer_gb, pen} <= 2'b00;
    wr_cmd(32'h0000_0200);
    wait_code(CODE_SEEK_TMO);
    chk("lines", 8'hC2, lines);
    ctrl_u.rd(REG_STATUS, d, r);
    chk("stat", CODE_SEEK_TMO, d[7:0]);
    ctrl_u.rd(32'h0000_0008, d, r);
    chk("rresp", 8'h02, {6'h0, r});
    $display("timeout test done");
  endtask
  task automatic t_recover;
    demod_ok <= 1'b0;
    wr_cmd(32'h0000_1000);
    wait_code(CODE_RTZ_DMOD);
    chk("lines", 8'hC6, lines);
    {demod_ok, outer_gb, pen} <= 3'b111;
    wr_cmd(32'h0000_1000);
    cyc(100);
    chk("retry", 8'h47, lines);
    {outer_gb, pen} <= 2'b00;
    wr_cmd(32'h0000_0100);
    outer_gb_pulse <= 1'b1;
    cyc(1);
    outer_gb_pulse <= 1'b0;
    wait_code(CODE_OUTER_GB);
    chk("lines", 8'hC2, lines);
    $display("recovery test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(2);
    aresetn <= 1'b1;
    t_load();
    t_seek();
    t_tmo();
    t_recover();
    give_verdict();
  end
  initial begin
    cyc(20000);
    failures++;
    give_verdict();
  end
endmodule
